// ---- mcs_defs.vh ----
// Behaviour
// [RQ1] Direction bit: zero restores, one saves
// [RQ2] Two-bit status: idle, done, busy, failed
// [RQ3] Codes 00b/01b vendor, 10b saves password
// [RQ4] Password save with direction zero: no action
// [RQ5] Code 11b restores or saves user area
// [RQ6] Sync bit marks interval start, self-clears
// [RQ7] Tick source bit: zero internal, one external
// [RQ8] Accumulation period is interval value plus one
// [RQ9] Accepted command: busy, then done or failed
`ifndef MCS_DEFS_VH
`define MCS_DEFS_VH

// ---------------------------------------------------------------
// Register word indices (byte address = index * 4)
// ---------------------------------------------------------------
`define MCS_IDX_CMD      16'hb004
`define MCS_IDX_OPCTL    16'hb00b
`define MCS_IDX_IRQ_STAT 16'hb010
`define MCS_IDX_IRQ_EN   16'hb011
`define MCS_IDX_IRQ_CLR  16'hb012
`define MCS_IDX_PERF_CNT 16'hb013

// ---------------------------------------------------------------
// Bus address and byte lanes
// ---------------------------------------------------------------
`define MCS_ADR_HI       17
`define MCS_ADR_LO       2
`define MCS_SEL_LO       0
`define MCS_SEL_HI       1

// ---------------------------------------------------------------
// Command register fields
// ---------------------------------------------------------------
`define MCS_CMD_DIR      5
`define MCS_CMD_STAT_HI  3
`define MCS_CMD_STAT_LO  2
`define MCS_CMD_EXT_HI   1
`define MCS_CMD_EXT_LO   0

`define MCS_EXT_VEND0    2'h0
`define MCS_EXT_VEND1    2'h1
`define MCS_EXT_PWD      2'h2
`define MCS_EXT_USER     2'h3

`define MCS_ST_IDLE      2'h0
`define MCS_ST_DONE      2'h1
`define MCS_ST_BUSY      2'h2
`define MCS_ST_FAIL      2'h3

// ---------------------------------------------------------------
// Operating control fields
// ---------------------------------------------------------------
`define MCS_OP_SYNC      11
`define MCS_OP_SRC       10
`define MCS_OP_IVL_HI    9
`define MCS_OP_IVL_LO    4

// ---------------------------------------------------------------
// Interrupt bits
// ---------------------------------------------------------------
`define MCS_IRQ_DONE     0
`define MCS_IRQ_FAIL     1
`define MCS_IRQ_PERIOD   2
`define MCS_IRQ_W        3

`endif

// ---- mcs_period.v ----
`timescale 1ns/1ns
`include "mcs_defs.vh"

// Counts one-second ticks into accumulation periods
module mcs_period #(
    parameter IVL_W = 6
) (
    // Clock and reset
    input  wire             i_mclk,
    input  wire             i_srst,
    // Control
    input  wire             i_tick,
    input  wire             i_sync,
    input  wire [IVL_W-1:0] i_interval,
    // Status
    output reg  [IVL_W-1:0] o_count,
    output reg              o_period_end
);

    // ---------------------------------------------------------------
    // Tick counter
    // ---------------------------------------------------------------
    // Sync restarts the count; period is interval plus one ticks
    always @(posedge i_mclk) begin
        if (i_srst) begin
            o_count      <= {IVL_W{1'b0}};
            o_period_end <= 1'b0;
        end else begin
            o_period_end <= 1'b0;
            if (i_sync) begin
                o_count <= {IVL_W{1'b0}}; // RQ6
            end else if (i_tick) begin
                if (o_count >= i_interval) begin
                    o_count      <= {IVL_W{1'b0}}; // RQ8
                    o_period_end <= 1'b1;
                end else begin
                    o_count <= o_count + {{(IVL_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule // mcs_period

// ---- mcs_top.v ----
`timescale 1ns/1ns
`include "mcs_defs.vh"

// Module command and setup registers with Wishbone slave
module mcs_top #(
    parameter IVL_W    = 6,
    parameter OP_TICKS = 8
) (
    // Clock and reset
    input  wire        i_mclk,
    input  wire        i_srst,
    // Wishbone slave
    input  wire        i_wb_cyc,
    input  wire        i_wb_stb,
    input  wire        i_wb_we,
    input  wire [17:0] i_wb_adr,
    input  wire [3:0]  i_wb_sel,
    input  wire [31:0] i_wb_dat,
    output reg  [31:0] o_wb_dat,
    output reg         o_wb_ack,
    // Tick sources
    input  wire        i_tick_int,
    input  wire        i_tick_ext,
    // Nonvolatile storage engine
    output reg         o_nv_start,
    output reg  [1:0]  o_nv_op,
    input  wire        i_nv_done,
    input  wire        i_nv_err,
    // Performance monitor
    output reg         o_perf_period_end,
    output reg         o_perf_tick,
    // Interrupt
    output reg         o_irq
);

    // Engine operation codes on o_nv_op
    localparam [1:0] OP_RESTORE = 2'h0;
    localparam [1:0] OP_SAVE    = 2'h1;
    localparam [1:0] OP_PWD     = 2'h2;

    // One-hot command states
    localparam [2:0] S_IDLE  = 3'h1;
    localparam [2:0] S_START = 3'h2;
    localparam [2:0] S_WAIT  = 3'h4;

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    reg              cmd_dir;
    reg  [1:0]       cmd_ext;
    reg  [1:0]       cmd_stat;
    reg              op_src;
    reg  [IVL_W-1:0] op_ivl;
    reg              op_sync;
    reg  [2:0]       state;
    reg  [`MCS_IRQ_W-1:0] irq_stat;
    reg  [`MCS_IRQ_W-1:0] irq_en;
    reg              ext_s1;
    reg              ext_s2;
    reg              ext_s3;
    reg              nv_done_s1;
    reg              nv_done_s2;
    reg              nv_err_s1;
    reg              nv_err_s2;

    wire [15:0]      word_idx;
    wire             access;
    wire             wr;
    wire             wr_lo;
    wire             wr_hi;
    wire             tick;
    wire             period_end;
    wire [IVL_W-1:0] tick_count;
    wire [IVL_W-1:0] ivl_wdat;
    wire             cmd_sel;
    wire             op_sel;
    wire             en_sel;
    wire             clr_sel;
    wire             cmd_wr;
    wire             op_wr;
    wire             ivl_wr;
    wire             en_wr;
    wire             clr_wr;
    wire [`MCS_IRQ_W-1:0] irq_set;
    wire [`MCS_IRQ_W-1:0] irq_clr;
    reg              cmd_go;
    reg  [1:0]       next_op;
    reg  [31:0]      next_rdat;

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------
    assign word_idx = i_wb_adr[`MCS_ADR_HI:`MCS_ADR_LO];
    assign access   = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    assign wr       = access & i_wb_we;
    assign wr_lo    = wr & i_wb_sel[`MCS_SEL_LO];
    assign wr_hi    = wr & i_wb_sel[`MCS_SEL_HI];
    assign ivl_wdat = i_wb_dat[`MCS_OP_IVL_HI:`MCS_OP_IVL_LO];

    // Register address matches
    assign cmd_sel  = (word_idx == `MCS_IDX_CMD);
    assign op_sel   = (word_idx == `MCS_IDX_OPCTL);
    assign en_sel   = (word_idx == `MCS_IDX_IRQ_EN);
    assign clr_sel  = (word_idx == `MCS_IDX_IRQ_CLR);

    // Write strobes; interval spans both low byte lanes
    assign cmd_wr   = wr_lo & cmd_sel;
    assign op_wr    = wr_hi & op_sel;
    assign ivl_wr   = wr_lo & wr_hi & op_sel;
    assign en_wr    = wr_lo & en_sel;
    assign clr_wr   = wr_lo & clr_sel;

    // Single-cycle acknowledge, dropped the cycle after
    always @(posedge i_mclk) begin
        if (i_srst) begin
            o_wb_ack <= 1'b0;
        end else begin
            o_wb_ack <= access;
        end
    end

    // Read mux; unmapped words read as zero
    always @* begin
        next_rdat = 32'h0000_0000;
        case (word_idx)
            `MCS_IDX_CMD: begin
                next_rdat[`MCS_CMD_DIR] = cmd_dir;
                next_rdat[`MCS_CMD_STAT_HI:`MCS_CMD_STAT_LO] = cmd_stat;
                next_rdat[`MCS_CMD_EXT_HI:`MCS_CMD_EXT_LO] = cmd_ext;
            end
            `MCS_IDX_OPCTL: begin
                next_rdat[`MCS_OP_SRC] = op_src;
                next_rdat[`MCS_OP_IVL_HI:`MCS_OP_IVL_LO] = op_ivl;
            end
            `MCS_IDX_IRQ_STAT: next_rdat[`MCS_IRQ_W-1:0] = irq_stat;
            `MCS_IDX_IRQ_EN:   next_rdat[`MCS_IRQ_W-1:0] = irq_en;
            `MCS_IDX_PERF_CNT: next_rdat[IVL_W-1:0] = tick_count;
            default:           next_rdat = 32'h0000_0000;
        endcase
    end

    // Read data register
    always @(posedge i_mclk) begin
        if (i_srst) begin
            o_wb_dat <= 32'h0000_0000;
        end else if (access & ~i_wb_we) begin
            o_wb_dat <= next_rdat;
        end
    end

    // ---------------------------------------------------------------
    // Command decode
    // ---------------------------------------------------------------
    // Classify a write to the command register
    // Vendor codes are stored but start nothing
    always @* begin
        cmd_go  = 1'b0;
        next_op = OP_RESTORE;
        if (cmd_wr && state == S_IDLE) begin
            case (i_wb_dat[`MCS_CMD_EXT_HI:`MCS_CMD_EXT_LO])
                `MCS_EXT_USER: begin
                    cmd_go  = 1'b1; // RQ5
                    next_op = i_wb_dat[`MCS_CMD_DIR] ? OP_SAVE
                                                     : OP_RESTORE; // RQ1
                end
                `MCS_EXT_PWD: begin
                    if (i_wb_dat[`MCS_CMD_DIR]) begin
                        cmd_go  = 1'b1; // RQ3
                        next_op = OP_PWD;
                    end else begin
                        cmd_go  = 1'b0; // RQ4
                    end
                end
                `MCS_EXT_VEND0: cmd_go = 1'b0; // RQ3
                `MCS_EXT_VEND1: cmd_go = 1'b0; // RQ3
                default:        cmd_go = 1'b0;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Engine result synchronisers
    // ---------------------------------------------------------------
    always @(posedge i_mclk) begin
        if (i_srst) begin
            nv_done_s1 <= 1'b0;
            nv_done_s2 <= 1'b0;
            nv_err_s1  <= 1'b0;
            nv_err_s2  <= 1'b0;
        end else begin
            nv_done_s1 <= i_nv_done;
            nv_done_s2 <= nv_done_s1;
            nv_err_s1  <= i_nv_err;
            nv_err_s2  <= nv_err_s1;
        end
    end

    // ---------------------------------------------------------------
    // Command state machine
    // ---------------------------------------------------------------
    // Accept, pulse start, wait for engine result
    always @(posedge i_mclk) begin
        if (i_srst) begin
            state      <= S_IDLE;
            cmd_stat   <= `MCS_ST_IDLE; // RQ9
            o_nv_start <= 1'b0;
            o_nv_op    <= OP_RESTORE;
        end else begin
            o_nv_start <= 1'b0;
            // Writes while busy are stored but start nothing
            case (state)
                S_IDLE: begin
                    if (cmd_go) begin
                        state    <= S_START;
                        cmd_stat <= `MCS_ST_BUSY; // RQ9
                        o_nv_op  <= next_op;
                    end
                end
                S_START: begin
                    o_nv_start <= 1'b1;
                    state      <= S_WAIT;
                end
                S_WAIT: begin
                    // Error wins if both results arrive
                    if (nv_err_s2) begin
                        cmd_stat <= `MCS_ST_FAIL; // RQ2
                        state    <= S_IDLE;
                    end else if (nv_done_s2) begin
                        cmd_stat <= `MCS_ST_DONE; // RQ2
                        state    <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Command register fields
    // ---------------------------------------------------------------
    // Fields stored on every write, busy or not
    always @(posedge i_mclk) begin
        if (i_srst) begin
            cmd_dir <= 1'b0;
            cmd_ext <= `MCS_EXT_VEND0;
        end else if (cmd_wr) begin
            cmd_dir <= i_wb_dat[`MCS_CMD_DIR]; // RQ1
            cmd_ext <= i_wb_dat[`MCS_CMD_EXT_HI:`MCS_CMD_EXT_LO]; // RQ3
        end
    end

    // ---------------------------------------------------------------
    // Operating control
    // ---------------------------------------------------------------
    // Source and interval stored; sync bit self-clears
    always @(posedge i_mclk) begin
        if (i_srst) begin
            op_src  <= 1'b0;
            op_ivl  <= {IVL_W{1'b0}};
            op_sync <= 1'b0;
        end else begin
            op_sync <= 1'b0; // RQ6
            if (op_wr) begin
                op_src  <= i_wb_dat[`MCS_OP_SRC]; // RQ7
                op_sync <= i_wb_dat[`MCS_OP_SYNC]; // RQ6
            end
            if (ivl_wr) begin
                op_ivl <= ivl_wdat; // RQ8
            end
        end
    end

    // ---------------------------------------------------------------
    // Tick selection
    // ---------------------------------------------------------------
    // External tick synchronised, then edge detected
    always @(posedge i_mclk) begin
        if (i_srst) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
        end else begin
            ext_s1 <= i_tick_ext;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    // Rising edge of the external tick, or the internal pulse
    assign tick = op_src ? (ext_s2 & ~ext_s3) : i_tick_int; // RQ7

    // Period counter
    mcs_period #(
        .IVL_W        (IVL_W)
    ) u_period (
        .i_mclk       (i_mclk),
        .i_srst       (i_srst),
        .i_tick       (tick),
        .i_sync       (op_sync),
        .i_interval   (op_ivl),
        .o_count      (tick_count),
        .o_period_end (period_end)
    );

    // Registered performance monitor outputs
    always @(posedge i_mclk) begin
        if (i_srst) begin
            o_perf_period_end <= 1'b0;
            o_perf_tick       <= 1'b0;
        end else begin
            o_perf_period_end <= period_end; // RQ8
            o_perf_tick       <= tick;
        end
    end

    // ---------------------------------------------------------------
    // Interrupts
    // ---------------------------------------------------------------
    // Events: period end, command failed, command done
    assign irq_set = {period_end,
                      (state == S_WAIT) & nv_err_s2,
                      (state == S_WAIT) & ~nv_err_s2 & nv_done_s2};

    // Write-one-to-clear mask from the clear register
    assign irq_clr = clr_wr ? i_wb_dat[`MCS_IRQ_W-1:0]
                            : {`MCS_IRQ_W{1'b0}};

    // Sticky status; a new event wins over a clear
    always @(posedge i_mclk) begin
        if (i_srst) begin
            irq_stat <= {`MCS_IRQ_W{1'b0}};
            irq_en   <= {`MCS_IRQ_W{1'b0}};
            o_irq    <= 1'b0;
        end else begin
            if (en_wr) begin
                irq_en <= i_wb_dat[`MCS_IRQ_W-1:0];
            end
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
            // Level output, one cycle behind the status
            o_irq    <= |(irq_stat & irq_en);
        end
    end

endmodule // mcs_top

// ---- mcs_nv_eng.sv ----
`timescale 1ns/1ns

// Storage engine model: answers each start after a set latency
module mcs_nv_eng (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_srst,
    // Request from the block
    input  wire logic       i_start,
    // Bench controls: failure and latency
    input  wire logic       i_fail,
    input  wire logic [3:0] i_lat,
    // Result lines, held three cycles
    output logic            o_done,
    output logic            o_err
);
    int cnt;
    int hold;

    // Latency count, then a held result level
    always @(posedge i_mclk) begin
        if (i_srst) begin
            cnt <= 0;
            hold <= 0;
            o_done <= 1'b0;
            o_err <= 1'b0;
        end else begin
            if (i_start) cnt <= i_lat + 1;
            else if (cnt > 1) cnt <= cnt - 1;
            else if (cnt == 1) begin
                cnt <= 0;
                hold <= 3;
            end
            if (hold > 0) hold <= hold - 1;
            o_done <= (hold > 0) && !i_fail;
            o_err <= (hold > 0) && i_fail;
        end
    end
endmodule // mcs_nv_eng

// ---- mcs_chk.sv ----
`timescale 1ns/1ns
`include "mcs_defs.vh"

// Port-level checks of the command and setup block
module mcs_chk (
    input  wire logic        i_mclk,
    input  wire logic        i_srst,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [17:0] i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic        o_wb_ack,
    input  wire logic        i_tick_int,
    input  wire logic        o_nv_start,
    input  wire logic [1:0]  o_nv_op,
    input  wire logic        o_perf_tick
);
    logic [3:0] since;
    logic [5:0] lw;
    logic       src;
    wire take = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wire cmdw = take && i_wb_we && i_wb_sel[0]
                && (i_wb_adr[17:2] == `MCS_IDX_CMD);
    wire opw = take && i_wb_we && i_wb_sel[1]
               && (i_wb_adr[17:2] == `MCS_IDX_OPCTL);

    // Last command write, its age and the tick source
    always @(posedge i_mclk) begin
        if (i_srst) begin
            since <= 4'hf;
            lw <= 6'h00;
            src <= 1'b0;
        end else begin
            if (cmdw) since <= 4'h0;
            else if (since != 4'hf) since <= since + 4'h1;
            if (cmdw) lw <= i_wb_dat[5:0];
            if (opw) src <= i_wb_dat[10];
        end
    end

    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    ack_after_take_a: assert property (take |=> o_wb_ack)
        else $error("ack missing after request");
    ack_single_a: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
        else $error("ack without request");
    start_cause_a: assert property (o_nv_start |-> since <= 4'h4)
        else $error("start without command write");
    start_op_a: assert property (o_nv_start |-> o_nv_op ==
        ((lw[1:0] == `MCS_EXT_PWD) ? 2'h2 : {1'b0, lw[5]}))
        else $error("start with wrong operation");
    no_action_a: assert property (cmdw && !(i_wb_dat[1:0] == 2'h3
        || (i_wb_dat[1:0] == 2'h2 && i_wb_dat[5])) |=> (!o_nv_start)[*4])
        else $error("start on a command with no action");
    start_pulse_a: assert property (o_nv_start |=> !o_nv_start)
        else $error("start longer than one cycle");
    tick_int_a: assert property (i_tick_int && !src |=> o_perf_tick)
        else $error("internal tick not passed");
    tick_only_a: assert property (o_perf_tick && !$past(src)
        |-> $past(i_tick_int))
        else $error("tick without internal source");
endmodule // mcs_chk

bind mcs_top mcs_chk chk_u (.i_mclk, .i_srst, .i_wb_cyc, .i_wb_stb,
    .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_ack, .i_tick_int,
    .o_nv_start, .o_nv_op, .o_perf_tick);

// ---- tb_top.sv ----
`timescale 1ns/1ns
`include "mcs_defs.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    err_total++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module tb_top;
    logic        i_mclk = 0, i_srst = 1, cyc = 0, stb = 0, we = 0;
    logic        tint = 0, text = 0, nv_fail = 0;
    logic [3:0]  sel = 0, nv_lat = 0;
    logic [17:0] adr = 0;
    logic [31:0] wdat = 0, rd;
    logic [1:0]  last_op, nv_op;
    wire  [31:0] o_wb_dat;
    wire         ack, nv_start, nv_done, nv_err, pend, ptick, irq;
    int          err_total = 0, n_tests = 0, cyc_cnt = 0;
    int          starts = 0, ends = 0, n;

    always #2 i_mclk = ~i_mclk;

    mcs_top dut_u (.i_mclk, .i_srst, .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat, .o_wb_ack(ack), .i_tick_int(tint), .i_tick_ext(text),
        .o_nv_start(nv_start), .o_nv_op(nv_op), .i_nv_done(nv_done),
        .i_nv_err(nv_err), .o_perf_period_end(pend), .o_perf_tick(ptick),
        .o_irq(irq));
    mcs_nv_eng eng_u (.i_mclk, .i_srst, .i_start(nv_start),
        .i_fail(nv_fail), .i_lat(nv_lat), .o_done(nv_done), .o_err(nv_err));

    // Event counters and hang guard
    always @(posedge i_mclk) begin
        cyc_cnt++;
        if (nv_start === 1'b1) begin
            starts++;
            last_op = nv_op;
        end
        if (pend === 1'b1) ends++;
        if (cyc_cnt == 6000) begin
            err_total++;
            final_report;
        end
    end

    task final_report;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // One classic Wishbone cycle, then one idle cycle
    task automatic wb(input logic w, input logic [15:0] i,
                      input logic [31:0] d);
        cyc <= 1; stb <= 1; we <= w; adr <= {i, 2'b00}; wdat <= d;
        sel <= 4'hf;
        @(posedge i_mclk);
        while (ack !== 1'b1) @(posedge i_mclk);
        rd = o_wb_dat;
        cyc <= 0; stb <= 0; we <= 0;
        @(posedge i_mclk);
    endtask

    task automatic rdchk(input logic [15:0] i, input logic [31:0] e,
                         input string nm);
        wb(0, i, 0);
        `CHK(nm, e, rd)
    endtask

    task automatic wait_cmd;
        for (int k = 0; k < 20; k++) begin
            wb(0, `MCS_IDX_CMD, 0);
            if (rd[3:2] !== `MCS_ST_BUSY) break;
        end
    endtask

    // Tick pulses: internal one cycle, external four cycles high
    task automatic tk(input logic ext, input int cnt);
        repeat (cnt) begin
            if (ext) text <= 1; else tint <= 1;
            @(posedge i_mclk);
            tint <= 0;
            repeat (3) @(posedge i_mclk);
            text <= 0;
            repeat (4) @(posedge i_mclk);
        end
    endtask

    initial begin
        repeat (12) @(posedge i_mclk);
        i_srst <= 0;
        @(posedge i_mclk);
        rdchk(`MCS_IDX_CMD, 32'h0, "cmd_reset");
        rdchk(`MCS_IDX_OPCTL, 32'h0, "op_reset");
        rdchk(16'h0123, 32'h0, "unmapped");
        $display("test reset done");
        wb(1, `MCS_IDX_IRQ_EN, 32'h3);
        nv_lat <= 12;
        wb(1, `MCS_IDX_CMD, 32'h23);
        rdchk(`MCS_IDX_CMD, 32'h2b, "cmd_busy");
        wait_cmd;
        `CHK("save_done", 32'h27, rd)
        `CHK("save_op", 2'h1, last_op)
        `CHK("irq_done", 1'b1, irq)
        rdchk(`MCS_IDX_IRQ_STAT, 32'h1, "stat_done");
        wb(1, `MCS_IDX_IRQ_CLR, 32'h1);
        repeat (2) @(posedge i_mclk);
        `CHK("irq_clear", 1'b0, irq)
        $display("test save done");
        nv_fail <= 1; nv_lat <= 1;
        wb(1, `MCS_IDX_CMD, 32'h03);
        wait_cmd;
        `CHK("restore_fail", 32'h0f, rd)
        `CHK("restore_op", 2'h0, last_op)
        rdchk(`MCS_IDX_IRQ_STAT, 32'h2, "stat_fail");
        `CHK("irq_fail", 1'b1, irq)
        wb(1, `MCS_IDX_IRQ_EN, 32'h0);
        repeat (2) @(posedge i_mclk);
        `CHK("irq_mask", 1'b0, irq)
        wb(1, `MCS_IDX_IRQ_CLR, 32'h3);
        $display("test restore done");
        n = starts;
        for (int c = 0; c < 3; c++) begin
            wb(1, `MCS_IDX_CMD, c);
            repeat (6) @(posedge i_mclk);
            rdchk(`MCS_IDX_CMD, 32'h0c | c, "no_action");
        end
        `CHK("no_start", n, starts)
        nv_fail <= 0;
        wb(1, `MCS_IDX_CMD, 32'h22);
        wait_cmd;
        `CHK("pwd_done", 32'h26, rd)
        `CHK("pwd_op", 2'h2, last_op)
        $display("test codes done");
        wb(1, `MCS_IDX_OPCTL, 32'h0820);
        n = ends;
        rdchk(`MCS_IDX_OPCTL, 32'h0020, "sync_clear");
        tk(0, 9);
        `CHK("int_periods", 3, ends - n)
        tk(0, 1);
        rdchk(`MCS_IDX_PERF_CNT, 32'h1, "count_one");
        wb(1, `MCS_IDX_OPCTL, 32'h0c10);
        rdchk(`MCS_IDX_PERF_CNT, 32'h0, "sync_restart");
        n = ends;
        tk(1, 6);
        `CHK("ext_periods", 3, ends - n)
        rdchk(`MCS_IDX_OPCTL, 32'h0410, "ext_src");
        rdchk(`MCS_IDX_IRQ_STAT, 32'h5, "stat_period");
        $display("test ticks done");
        final_report;
    end
endmodule // tb_top
